// ---- srl_pkg.sv ----
// package: register map, field positions and types of the multi-source set-reset latch
package srl_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [11:0] SRL_ADDR_CONTROL = 12'h000;  // latch_control_main
  localparam logic [11:0] SRL_ADDR_SOURCES = 12'h004;  // latch_source_enables
  localparam logic [11:0] SRL_ADDR_PINSEL  = 12'h008;  // alt_pin_function_control
  localparam logic [11:0] SRL_ADDR_STATUS  = 12'h00C;  // latch and source state

  // ==========================================================================
  // reset values
  localparam logic [7:0] SRL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SRL_SOURCES_RESET = 8'h00;
  localparam logic [7:0] SRL_PINSEL_RESET  = 8'h00;

  // ==========================================================================
  // latch_control_main fields
  localparam int SRL_CTL_ENABLE   = 7;  // latch_module_enable
  localparam int SRL_CTL_DIV_HI   = 6;  // divided_pulse_select msb
  localparam int SRL_CTL_DIV_LO   = 4;  // divided_pulse_select lsb
  localparam int SRL_CTL_TRUE_OE  = 3;  // true_out_enable
  localparam int SRL_CTL_COMPL_OE = 2;  // compl_out_enable
  localparam int SRL_CTL_SW_SET   = 1;  // sw_set_pulse
  localparam int SRL_CTL_SW_RST   = 0;  // sw_reset_pulse

  // ==========================================================================
  // latch_source_enables fields
  localparam int SRL_SRC_PIN_SET   = 7;
  localparam int SRL_SRC_PULSE_SET = 6;
  localparam int SRL_SRC_CMP2_SET  = 5;
  localparam int SRL_SRC_CMP1_SET  = 4;
  localparam int SRL_SRC_PIN_RST   = 3;
  localparam int SRL_SRC_PULSE_RST = 2;
  localparam int SRL_SRC_CMP2_RST  = 1;
  localparam int SRL_SRC_CMP1_RST  = 0;

  // alt_pin_function_control field
  localparam int SRL_PIN_COMPL_ALT = 0;  // compl_pin_alt_select

  // ==========================================================================
  // divider: period is 2^(code + base) clock cycles
  localparam int SRL_DIV_SEL_W   = 3;
  localparam int SRL_DIV_CNT_W   = 9;
  localparam int SRL_DIV_LOG_MIN = 2;

  // ==========================================================================
  // ahb constants
  localparam logic [1:0] SRL_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SRL_HTRANS_SEQ    = 2'h3;

  // latch source bundle
  typedef struct packed {
    logic sw;
    logic cmp1;
    logic cmp2;
    logic pin;
    logic pulse;
  } srl_src_t;

  // pin driver bundle
  typedef struct packed {
    logic data;
    logic oe;
  } srl_pin_t;

endpackage

// ---- srl_divider.sv ----
// module: free-running divider producing a periodic one-cycle pulse
`timescale 1ns/1ps
module srl_divider
  import srl_pkg::*;
#(
  parameter int SEL_W = SRL_DIV_SEL_W,
  parameter int CNT_W = SRL_DIV_CNT_W
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [SEL_W-1:0] i_select,
  output logic                  o_pulse
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] terminal;

  // ==========================================================================
  // terminal count is 2^(code+2) - 1
  always_comb begin
    terminal = CNT_W'((1 << (32'(i_select) + SRL_DIV_LOG_MIN)) - 1);
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      count_reg <= '0;
    end else if (count_reg >= terminal) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= (count_reg == terminal);
    end
  end

endmodule

// ---- srl_sync.sv ----
// module: three-stage synchroniser with agreement filter for the pin and comparator inputs
`timescale 1ns/1ps
module srl_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // ==========================================================================
  // shift chain
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // output changes once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          o_sync[g] <= 1'b0;
        end else if (stage2_reg[g] == stage3_reg[g]) begin
          o_sync[g] <= stage3_reg[g];
        end
      end
    end
  endgenerate

endmodule

// ---- srl_top.sv ----
// module: multi-source set-reset latch with ahb-lite register access
//
// Overview of operation
// - latch samples active-high set and reset inputs on the rising clock edge
// - set and reset high together leave the latch reset
// - writing one to sw_set_pulse pulses set for one cycle
// - writing one to sw_reset_pulse pulses reset for one cycle
// - both software pulse bits clear themselves and read as zero
// - divider pulses once every 2^(code+2) clocks, one clock wide
// - pulse_set_enable lets divider pulses set the latch
// - pulse_reset_enable lets divider pulses reset the latch
// - pin_set_enable lets the input pin set the latch while high
// - pin_reset_enable lets the input pin reset the latch while high
// - comparator set enables let each comparator set the latch while high
// - comparator reset enables let each comparator reset the latch while high
// - set and reset are each the or of their enabled sources
// - comparator inputs are the already synchronised comparator outputs
// - module enable gates both output enables; the latch runs regardless
// - true output enable drives latch q onto its pin
// - complement output enable drives inverted q onto its pin
// - both outputs may drive at once; alt select moves complement pin
// - latch state has no defined reset value; firmware initialises it
`timescale 1ns/1ps
module srl_top
  import srl_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [11:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // latch sources
  input  wire logic        i_cmp1_synced_out,
  input  wire logic        i_cmp2_synced_out,
  input  wire logic        i_latch_ext_input_pin,
  // latch outputs
  output logic             o_true_out_pin,
  output logic             o_true_out_pin_oe,
  output logic             o_compl_out_pin,
  output logic             o_compl_out_pin_oe,
  output logic             o_compl_alt_pin,
  output logic             o_compl_alt_pin_oe
);

  // ==========================================================================
  // declarations
  logic [7:0]  control_reg;
  logic [7:0]  sources_reg;
  logic [7:0]  pinsel_reg;
  logic        sw_set_reg;
  logic        sw_rst_reg;
  logic        latch_q_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] rdata_next;
  logic        addr_phase;
  logic        div_pulse;
  logic [2:0]  pins_sync;
  srl_src_t    set_src;
  srl_src_t    rst_src;
  logic        set_in;
  logic        rst_in;
  logic        enable;
  srl_pin_t    true_pin;
  srl_pin_t    compl_pin;

  assign enable = control_reg[SRL_CTL_ENABLE];

  // ==========================================================================
  // input synchronisation
  // comparators arrive already synced
  srl_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_cmp2_synced_out, i_cmp1_synced_out, i_latch_ext_input_pin}),
    .o_sync  (pins_sync)
  );

  // ==========================================================================
  // divided pulse generator
  // divider rate from control field
  srl_divider #(
    .SEL_W (SRL_DIV_SEL_W),
    .CNT_W (SRL_DIV_CNT_W)
  ) u_div (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_select (control_reg[SRL_CTL_DIV_HI:SRL_CTL_DIV_LO]),
    .o_pulse  (div_pulse)
  );

  // ==========================================================================
  // ahb-lite slave
  assign addr_phase = i_hsel && i_hready &&
                      (i_htrans == SRL_HTRANS_NONSEQ || i_htrans == SRL_HTRANS_SEQ);

  // capture write address phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_phase && i_hwrite;
      if (addr_phase) begin
        wr_addr_reg <= i_haddr;
      end
    end
  end

  // control register; pulse bits never stored
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      control_reg <= SRL_CONTROL_RESET;
    end else if (wr_pend_reg && wr_addr_reg == SRL_ADDR_CONTROL) begin
      control_reg <= {i_hwdata[7:2], 2'b00};
    end
  end

  // source enable and pin select registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sources_reg <= SRL_SOURCES_RESET;
      pinsel_reg  <= SRL_PINSEL_RESET;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == SRL_ADDR_SOURCES) begin
        sources_reg <= i_hwdata[7:0];
      end
      if (wr_addr_reg == SRL_ADDR_PINSEL) begin
        pinsel_reg <= {7'h00, i_hwdata[SRL_PIN_COMPL_ALT]};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sw_set_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
    end else begin
      sw_set_reg <= wr_pend_reg && wr_addr_reg == SRL_ADDR_CONTROL &&
                    i_hwdata[SRL_CTL_SW_SET];
      sw_rst_reg <= wr_pend_reg && wr_addr_reg == SRL_ADDR_CONTROL &&
                    i_hwdata[SRL_CTL_SW_RST];
    end
  end

  // read mux; unmapped reads zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (i_haddr)
      SRL_ADDR_CONTROL: rdata_next = {24'h00_0000, control_reg};
      SRL_ADDR_SOURCES: rdata_next = {24'h00_0000, sources_reg};
      SRL_ADDR_PINSEL:  rdata_next = {24'h00_0000, pinsel_reg};
      SRL_ADDR_STATUS:  rdata_next = {28'h000_0000, pins_sync, latch_q_reg};
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  // read data registered into data phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_phase && !i_hwrite) begin
      o_hrdata <= rdata_next;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // ==========================================================================
  // source selection
  // set sources: software, comparators, pin and divider pulse
  always_comb begin
    set_src.sw    = sw_set_reg;
    set_src.cmp1  = sources_reg[SRL_SRC_CMP1_SET] && pins_sync[1];
    set_src.cmp2  = sources_reg[SRL_SRC_CMP2_SET] && pins_sync[2];
    set_src.pin   = sources_reg[SRL_SRC_PIN_SET] && pins_sync[0];
    set_src.pulse = sources_reg[SRL_SRC_PULSE_SET] && div_pulse;
  end

  always_comb begin
    rst_src.sw    = sw_rst_reg;
    rst_src.cmp1  = sources_reg[SRL_SRC_CMP1_RST] && pins_sync[1];
    rst_src.cmp2  = sources_reg[SRL_SRC_CMP2_RST] && pins_sync[2];
    rst_src.pin   = sources_reg[SRL_SRC_PIN_RST] && pins_sync[0];
    rst_src.pulse = sources_reg[SRL_SRC_PULSE_RST] && div_pulse;
  end

  assign set_in = |set_src;
  assign rst_in = |rst_src;

  // ==========================================================================
  // latch core
  // level inputs, state held otherwise
  // firmware keeps a source on one side
  always_ff @(posedge i_clock) begin
    if (rst_in) begin
      latch_q_reg <= 1'b0;
    end else if (set_in) begin
      latch_q_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // output pins
  // module enable gates outputs
  always_comb begin
    true_pin.data  = latch_q_reg;
    true_pin.oe    = enable && control_reg[SRL_CTL_TRUE_OE];
    compl_pin.data = !latch_q_reg;
    compl_pin.oe   = enable && control_reg[SRL_CTL_COMPL_OE];
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_true_out_pin     <= 1'b0;
      o_true_out_pin_oe  <= 1'b0;
      o_compl_out_pin    <= 1'b0;
      o_compl_out_pin_oe <= 1'b0;
      o_compl_alt_pin    <= 1'b0;
      o_compl_alt_pin_oe <= 1'b0;
    end else begin
      o_true_out_pin     <= true_pin.data;
      o_true_out_pin_oe  <= true_pin.oe;
      o_compl_out_pin    <= compl_pin.data;
      o_compl_out_pin_oe <= compl_pin.oe && !pinsel_reg[SRL_PIN_COMPL_ALT];
      o_compl_alt_pin    <= compl_pin.data;
      o_compl_alt_pin_oe <= compl_pin.oe && pinsel_reg[SRL_PIN_COMPL_ALT];
    end
  end

endmodule

// ---- srl_far_side.sv ----
// far-side model: comparator outputs and the external input pin
`timescale 1ns/1ps
module srl_far_side (
  input  wire logic       i_clock,
  input  wire logic [2:0] i_level,
  output logic            o_pin,
  output logic            o_cmp1,
  output logic            o_cmp2
);
  // ==========================================================================
  // source levels, changed just after a clock edge
  // comparators present synchronised outputs
  always_ff @(posedge i_clock) begin
    {o_pin, o_cmp1, o_cmp2} <= i_level;
  end
endmodule

// ---- srl_checker.sv ----
// checker: port-level properties of the multi-source latch
`timescale 1ns/1ps
module srl_checker
  import srl_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [11:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  logic             o_hreadyout,
  input  logic             o_hresp,
  input  wire logic        i_cmp1_synced_out,
  input  wire logic        i_cmp2_synced_out,
  input  wire logic        i_latch_ext_input_pin,
  input  logic             o_true_out_pin,
  input  logic             o_true_out_pin_oe,
  input  logic             o_compl_out_pin,
  input  logic             o_compl_out_pin_oe,
  input  logic             o_compl_alt_pin_oe
);
  logic        wr_ph_reg;  // write data phase follows
  logic [11:0] wa_reg;     // address of that write
  logic [7:0]  ctl_reg;
  logic [7:0]  src_reg;
  logic        alt_reg;
  logic [3:0]  quiet_reg;  // cycles since last write

  // ==========================================================================
  // bus decode of write address phases
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_ph_reg <= 1'b0;
      wa_reg    <= 12'h000;
    end else if (i_hready) begin
      wr_ph_reg <= i_hsel & i_htrans[1] & i_hwrite;
      wa_reg    <= i_haddr;
    end
  end

  // shadow copies of the written registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctl_reg   <= 8'h00;
      src_reg   <= 8'h00;
      alt_reg   <= 1'b0;
      quiet_reg <= 4'h0;
    end else if (wr_ph_reg) begin
      quiet_reg <= 4'h0;
      if (wa_reg == SRL_ADDR_CONTROL) ctl_reg <= i_hwdata[7:0];
      if (wa_reg == SRL_ADDR_SOURCES) src_reg <= i_hwdata[7:0];
      if (wa_reg == SRL_ADDR_PINSEL) alt_reg <= i_hwdata[SRL_PIN_COMPL_ALT];
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  okay_resp_a: assert property (!o_hresp)
    else $error("bus response not okay");
  ready_high_a: assert property ($past(i_rst_n) |-> o_hreadyout)
    else $error("slave not ready out of reset");
  compl_inverse_a: assert property (o_true_out_pin_oe && o_compl_out_pin_oe
    |-> o_compl_out_pin != o_true_out_pin) else $error("complement pin not inverse");
  oe_gate_a: assert property (quiet_reg >= 3
    |-> o_true_out_pin_oe == (ctl_reg[7] & ctl_reg[3])) else $error("true pin enable wrong");
  compl_route_a: assert property (quiet_reg >= 3 |->
    o_compl_out_pin_oe == (ctl_reg[7] & ctl_reg[2] & !alt_reg) &&
    o_compl_alt_pin_oe == (ctl_reg[7] & ctl_reg[2] & alt_reg)) else $error("complement route");
  reset_wins_a: assert property ((ctl_reg[7] && src_reg[3] && i_latch_ext_input_pin
    && quiet_reg >= 3)[*8] |-> !o_true_out_pin) else $error("pin reset not held");
  pin_set_a: assert property ((ctl_reg[7] && src_reg[7] && src_reg[3:0] == 4'h0
    && i_latch_ext_input_pin && quiet_reg >= 3)[*8] |-> o_true_out_pin) else $error("pin set");
  cmp_set_a: assert property ((ctl_reg[7] && src_reg[5] && src_reg[3:0] == 4'h0
    && i_cmp2_synced_out && quiet_reg >= 3)[*8] |-> o_true_out_pin) else $error("cmp2 set");
  cmp_reset_a: assert property ((ctl_reg[7] && src_reg[0] && i_cmp1_synced_out
    && quiet_reg >= 3)[*8] |-> !o_true_out_pin) else $error("cmp1 reset");
endmodule

bind srl_top srl_checker srl_checker_inst (.i_clock, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .i_cmp1_synced_out,
  .i_cmp2_synced_out, .i_latch_ext_input_pin, .o_true_out_pin, .o_true_out_pin_oe,
  .o_compl_out_pin, .o_compl_out_pin_oe, .o_compl_alt_pin_oe);

// ---- tb_srl_top.sv ----
// testbench: registers, latch sources, output routing and divider period
`timescale 1ns/1ps
module tb_srl_top;
  import srl_pkg::*;
  logic        i_clock;
  logic        i_rst_n;
  logic        i_hsel;
  logic [11:0] i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  logic        i_hready;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic [2:0]  level;  // requested pin, cmp1, cmp2
  logic        pin;
  logic        cmp1;
  logic        cmp2;
  logic        o_true_out_pin;
  logic        o_true_out_pin_oe;
  logic        o_compl_out_pin;
  logic        o_compl_out_pin_oe;
  logic        o_compl_alt_pin_oe;
  logic        o_compl_alt_pin;
  logic [31:0] rd;
  int          failures;
  int          num_checks;

  // ==========================================================================
  // clock, bus ready and instances
  initial i_clock = 1'b0;
  always #10 i_clock = ~i_clock;
  assign i_hready = o_hreadyout;

  srl_far_side srl_far_side_inst (.i_clock, .i_level(level), .o_pin(pin), .o_cmp1(cmp1),
    .o_cmp2(cmp2));
  srl_top srl_top_inst (.i_clock, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_cmp1_synced_out(cmp1),
    .i_cmp2_synced_out(cmp2), .i_latch_ext_input_pin(pin), .o_true_out_pin, .o_true_out_pin_oe,
    .o_compl_out_pin, .o_compl_out_pin_oe, .o_compl_alt_pin, .o_compl_alt_pin_oe);

  // ==========================================================================
  // reporting and comparisons
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // ==========================================================================
  // bus transfers, bounded waits
  task automatic wait_ready();
    for (int i = 0; i < 50; i++) begin
      @(posedge i_clock);
      if (o_hreadyout === 1'b1) return;
    end
    $display("[ERR] %0t timeout waiting for bus ready", $time);
    failures++;
    finish_test();
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_hsel   <= 1'b1;
    i_haddr  <= a;
    i_htrans <= SRL_HTRANS_NONSEQ;
    i_hwrite <= wr;
    wait_ready();
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_ready();
    rd = o_hrdata;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check_word(rd, exp, "register read");
  endtask

  // raise sources, judge the latch, then drop them
  task automatic drive(input logic [2:0] lv, input logic exp, input string what);
    @(posedge i_clock);
    level <= lv;
    settle(9);
    check_bit(o_true_out_pin, exp, what);
    @(posedge i_clock);
    level <= 3'b000;
    settle(8);
  endtask

  task automatic wait_fall(output int n);
    logic prev;
    prev = o_true_out_pin;
    for (n = 1; n < 1100; n++) begin
      @(posedge i_clock);
      #1;
      if (prev === 1'b1 && o_true_out_pin === 1'b0) return;
      prev = o_true_out_pin;
    end
    $display("[ERR] %0t timeout waiting for latch fall", $time);
    failures++;
    finish_test();
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    check_bit(o_true_out_pin_oe | o_compl_out_pin_oe | o_compl_alt_pin_oe, 1'b0, "oe");
    rdchk(SRL_ADDR_CONTROL, 32'h0000_0000);
    rdchk(SRL_ADDR_SOURCES, 32'h0000_0000);
    rdchk(SRL_ADDR_PINSEL, 32'h0000_0000);
    bus(1'b1, SRL_ADDR_SOURCES, 32'h0000_00A5);
    rdchk(SRL_ADDR_SOURCES, 32'h0000_00A5);
    bus(1'b1, 12'h010, 32'h0000_00FF);
    rdchk(12'h010, 32'h0000_0000);
  endtask

  task automatic t_sw();
    bus(1'b1, SRL_ADDR_SOURCES, 32'h0000_0000);
    // pin direction belongs to firmware; oe and pin levels are judged
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_0081);
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_008E);
    settle(3);
    check_bit(o_true_out_pin, 1'b1, "software set");
    check_bit(o_compl_out_pin_oe & o_true_out_pin_oe, 1'b1, "both oe");
    rdchk(SRL_ADDR_CONTROL, 32'h0000_008C);
    rdchk(SRL_ADDR_STATUS, 32'h0000_0001);
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_008C);
    settle(3);
    check_bit(o_true_out_pin, 1'b1, "zero bits keep state");
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_008D);
    settle(3);
    check_bit(o_compl_out_pin, 1'b1, "software reset");
    bus(1'b1, SRL_ADDR_PINSEL, 32'h0000_0001);
    settle(3);
    check_bit(o_compl_alt_pin_oe & !o_compl_out_pin_oe, 1'b1, "alt pin");
    check_bit(o_compl_alt_pin, 1'b1, "alt pin data");
    bus(1'b1, SRL_ADDR_PINSEL, 32'h0000_0000);
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_000C);
    settle(3);
    check_bit(o_true_out_pin_oe | o_compl_out_pin_oe, 1'b0, "disabled oe");
  endtask

  task automatic t_sources();
    int setb[3] = '{7, 4, 5};
    int rstb[3] = '{3, 0, 1};
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_0089);
    for (int s = 0; s < 3; s++) begin
      // no source enabled for set and reset at once
      bus(1'b1, SRL_ADDR_SOURCES, 32'(1) << setb[s]);
      drive(3'b100 >> s, 1'b1, "source set");
      bus(1'b1, SRL_ADDR_SOURCES, 32'(1) << rstb[s]);
      drive(3'b100 >> s, 1'b0, "source reset");
      bus(1'b1, SRL_ADDR_SOURCES, 32'h0000_0000);
      drive(3'b100 >> s, 1'b0, "source disabled");
    end
    bus(1'b1, SRL_ADDR_SOURCES, 32'h0000_0081);
    drive(3'b110, 1'b0, "reset dominates");
  endtask

  task automatic t_divider();
    int n;
    bus(1'b1, SRL_ADDR_SOURCES, 32'h0000_0084);
    @(posedge i_clock);
    level <= 3'b100;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_0088 | (32'(c) << 4));
      settle(1);
      wait_fall(n);
      settle(1);
      check_bit(o_true_out_pin, 1'b1, "pulse width");
      wait_fall(n);
      check_word(32'(n + 1), 32'(1) << (c + 2), "divider period");
    end
    @(posedge i_clock);
    level <= 3'b000;
    // shortest divider period so a set pulse follows the released reset
    bus(1'b1, SRL_ADDR_CONTROL, 32'h0000_0088);
    bus(1'b1, SRL_ADDR_SOURCES, 32'h0000_0041);
    drive(3'b010, 1'b0, "reset over pulse set");
    settle(6);
    check_bit(o_true_out_pin, 1'b1, "pulse set");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    failures   = 0;
    num_checks = 0;
    i_rst_n    = 1'b0;
    i_hsel     = 1'b0;
    i_haddr    = 12'h000;
    i_htrans   = 2'h0;
    i_hwrite   = 1'b0;
    i_hsize    = 3'h2;
    i_hwdata   = 32'h0000_0000;
    level      = 3'b000;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    settle(1);
    t_regs();
    t_sw();
    t_sources();
    t_divider();
    finish_test();
  end
endmodule
